// file: logic/e1c_reg_map.svh
// Register map, field positions and codes of the E1 receive CAS/spare block
`ifndef E1C_REG_MAP_SVH
`define E1C_REG_MAP_SVH

// ==========================================================
// Byte offsets
`define E1C_OFS_CAS0 16'h0100
`define E1C_OFS_CAS1 16'h0104
`define E1C_OFS_CAS2 16'h0108
`define E1C_OFS_CTRL 16'h010C
`define E1C_OFS_CAS3 16'h0110
`define E1C_OFS_NAT 16'h0114
`define E1C_OFS_INT_STAT 16'h0118
`define E1C_OFS_INT_MASK 16'h011C

// ==========================================================
// Reset values and codes
`define E1C_SEL_RESET 3'h0
`define E1C_SEL_CAS_A 3'h1
`define E1C_SEL_CAS_B 3'h3
`define E1C_MASK_RESET 2'h0
`define E1C_RESP_OKAY 2'h0
`define E1C_RESP_DECERR 2'h3

// ==========================================================
// Field positions
`define E1C_CTRL_SEL 2:0
`define E1C_INT_CAS 0
`define E1C_INT_NAT 1
`define E1C_NAT_INTL_BIT_ALIGN_FRAME 7
`define E1C_NAT_SI_NF 6
`define E1C_NAT_RAI 5
`define E1C_NAT_SPARE 4:0
`define E1C_OCT_SI 7
`define E1C_OCT_RAI 5
`define E1C_OCT_SPARE 4:0
`define E1C_TS_ALIGN 0

`endif

// file: logic/e1c_pkg.sv
// Types shared by the E1 receive CAS/spare block
package e1c_pkg;

    // One received CAS nibble for one timeslot
    typedef struct packed {
        logic valid;
        logic [4:0] ts;
        logic [3:0] abcd;
    } e1c_sig_s;

    // Timeslot 0 octet of one received frame
    typedef struct packed {
        logic valid;
        logic fas;
        logic [7:0] octet;
    } e1c_ts0_s;

    typedef logic [7:0] e1c_byte_t;

endpackage

// file: logic/e1c_cas_track.sv
// Per-timeslot CAS change detection and sticky change flags
`timescale 1ns/10ps
`include "e1c_reg_map.svh"
module e1c_cas_track #(
    parameter int NTS = 32,
    parameter int SIGW = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire e1c_pkg::e1c_sig_s sig,
    input wire logic cas_en,
    input wire logic [NTS-1:0] clr,
    output logic [NTS-1:0] flags,
    output logic change
);
    import e1c_pkg::*;

    logic [SIGW-1:0] prev_mem [NTS];
    logic [NTS-1:0] seen;
    logic [NTS-1:0] set_vec;

    // ==========================================================
    // Last nibble per timeslot; data only, so no reset needed
    always_ff @(posedge clk) begin
        if (sig.valid) begin
            prev_mem[sig.ts] <= sig.abcd[SIGW-1:0];
        end
    end

    // ==========================================================
    // Flags
    genvar i;
    generate
        for (i = 0; i < NTS; i++) begin : g_ts
            // First nibble after reset has nothing to compare with
            always_ff @(posedge clk) begin
                if (rst) begin
                    seen[i] <= 1'b0;
                end else if (sig.valid && sig.ts == 5'(i)) begin
                    seen[i] <= 1'b1;
                end
            end

            assign set_vec[i] = cas_en && (i != `E1C_TS_ALIGN)
                && sig.valid && sig.ts == 5'(i) && seen[i]
                && prev_mem[i] != sig.abcd[SIGW-1:0];

            always_ff @(posedge clk) begin
                if (rst || !cas_en) begin
                    flags[i] <= 1'b0;
                end else begin
                    // Set wins over the read clear
                    flags[i] <= (flags[i] & ~clr[i]) | set_vec[i];
                end
            end
        end
    endgenerate

    assign change = |set_vec;

endmodule // e1c_cas_track

// file: logic/e1c_nat_capture.sv
// Capture of international, remote alarm and national spare bits
`timescale 1ns/10ps
`include "e1c_reg_map.svh"
module e1c_nat_capture (
    input wire logic clk,
    input wire logic rst,
    input wire e1c_pkg::e1c_ts0_s ts0,
    output e1c_pkg::e1c_byte_t nat,
    output logic updated
);
    import e1c_pkg::*;

    // ==========================================================
    // Captured bits hold no reset value: they are unknown until the
    // first frame of each kind arrives
    always_ff @(posedge clk) begin
        if (ts0.valid && ts0.fas) begin
            nat[`E1C_NAT_INTL_BIT_ALIGN_FRAME] <= ts0.octet[`E1C_OCT_SI];
        end
        if (ts0.valid && !ts0.fas) begin
            nat[`E1C_NAT_SI_NF] <= ts0.octet[`E1C_OCT_SI];
            nat[`E1C_NAT_RAI] <= ts0.octet[`E1C_OCT_RAI];
            nat[`E1C_NAT_SPARE] <= ts0.octet[`E1C_OCT_SPARE];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            updated <= 1'b0;
        end else begin
            updated <= ts0.valid;
        end
    end

endmodule // e1c_nat_capture

// file: logic/e1c_top.sv
// E1 receive CAS change flags and spare bits behind an AXI4-Lite slave
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
`include "e1c_reg_map.svh"
module e1c_top #(
    parameter int AW = 16,
    parameter int NTS = 32
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [AW-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [AW-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire e1c_pkg::e1c_sig_s RX_SIG,
    input wire e1c_pkg::e1c_ts0_s RX_TS0,
    output logic IRQ
);
    import e1c_pkg::*;

    localparam int NREG = NTS / 8;

    // ==========================================================
    // Declarations
    logic aw_full;
    logic w_full;
    logic [AW-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    logic rd_go;
    logic [2:0] rx_signaling_link_select;
    logic [1:0] int_mask;
    logic [1:0] int_stat;
    logic [1:0] int_event;
    logic int_clr;
    logic cas_en;
    logic cas_change;
    logic nat_updated;
    e1c_byte_t nat;
    logic [NTS-1:0] flags;
    logic [NTS-1:0] flag_clr;
    logic [NREG-1:0] rd_clr;
    e1c_byte_t cas_reg [NREG];
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    // ==========================================================
    // Change tracking and spare bit capture
    e1c_cas_track #(
        .NTS(NTS),
        .SIGW(4)
    ) u_track (
        .clk(CLK),
        .rst(RST),
        .sig(RX_SIG),
        .cas_en(cas_en),
        .clr(flag_clr),
        .flags(flags),
        .change(cas_change)
    );

    e1c_nat_capture u_nat (
        .clk(CLK),
        .rst(RST),
        .ts0(RX_TS0),
        .nat(nat),
        .updated(nat_updated)
    );

    assign cas_en = rx_signaling_link_select == `E1C_SEL_CAS_A
        || rx_signaling_link_select == `E1C_SEL_CAS_B;

    // ==========================================================
    // Timeslot to register bit mapping: lowest timeslot on bit 7
    genvar r;
    genvar b;
    generate
        for (r = 0; r < NREG; r++) begin : g_reg
            for (b = 0; b < 8; b++) begin : g_bit
                assign cas_reg[r][b] = flags[r * 8 + 7 - b];
                assign flag_clr[r * 8 + 7 - b] = rd_clr[r];
            end
        end
    endgenerate

    // ==========================================================
    // Write channel: address and data taken in either order
    assign S_AXI_AWREADY = !aw_full;
    assign S_AXI_WREADY = !w_full;
    assign wr_go = aw_full && w_full && !S_AXI_BVALID;

    always_ff @(posedge CLK) begin
        if (RST) begin
            aw_full <= 1'b0;
            aw_addr <= '0;
        end else if (S_AXI_AWVALID && !aw_full) begin
            aw_full <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
        end else if (wr_go) begin
            aw_full <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            w_full <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (S_AXI_WVALID && !w_full) begin
            w_full <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
        end else if (wr_go) begin
            w_full <= 1'b0;
        end
    end

    // Writes to read-only words are accepted and dropped
    always_ff @(posedge CLK) begin
        if (RST) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `E1C_RESP_OKAY;
        end else if (wr_go) begin
            S_AXI_BVALID <= 1'b1;
            case (aw_addr)
                `E1C_OFS_CAS0, `E1C_OFS_CAS1, `E1C_OFS_CAS2,
                `E1C_OFS_CAS3, `E1C_OFS_CTRL, `E1C_OFS_NAT,
                `E1C_OFS_INT_STAT, `E1C_OFS_INT_MASK: begin
                    S_AXI_BRESP <= `E1C_RESP_OKAY;
                end
                default: begin
                    S_AXI_BRESP <= `E1C_RESP_DECERR;
                end
            endcase
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // ==========================================================
    // Control and mask registers
    always_ff @(posedge CLK) begin
        if (RST) begin
            rx_signaling_link_select <= `E1C_SEL_RESET;
        end else if (wr_go && aw_addr == `E1C_OFS_CTRL && w_strb[0]) begin
            rx_signaling_link_select <= w_data[`E1C_CTRL_SEL];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            int_mask <= `E1C_MASK_RESET;
        end else if (wr_go && aw_addr == `E1C_OFS_INT_MASK
                     && w_strb[0]) begin
            int_mask <= w_data[1:0];
        end
    end

    // ==========================================================
    // Read channel: one outstanding read, answer one edge later
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    assign rd_go = S_AXI_ARVALID && !S_AXI_RVALID;

    // The fourth change word skips over the control word
    always_comb begin
        rd_clr = '0;
        if (rd_go) begin
            rd_clr[0] = S_AXI_ARADDR == `E1C_OFS_CAS0;
            rd_clr[1] = S_AXI_ARADDR == `E1C_OFS_CAS1;
            rd_clr[2] = S_AXI_ARADDR == `E1C_OFS_CAS2;
            rd_clr[3] = S_AXI_ARADDR == `E1C_OFS_CAS3;
        end
    end

    always_comb begin
        next_rdata = '0;
        next_rresp = `E1C_RESP_OKAY;
        case (S_AXI_ARADDR)
            `E1C_OFS_CAS0: next_rdata[7:0] = cas_reg[0];
            `E1C_OFS_CAS1: next_rdata[7:0] = cas_reg[1];
            `E1C_OFS_CAS2: next_rdata[7:0] = cas_reg[2];
            `E1C_OFS_CAS3: next_rdata[7:0] = cas_reg[3];
            `E1C_OFS_CTRL: begin
                next_rdata[`E1C_CTRL_SEL] = rx_signaling_link_select;
            end
            `E1C_OFS_NAT: next_rdata[7:0] = nat;
            `E1C_OFS_INT_STAT: next_rdata[1:0] = int_stat;
            `E1C_OFS_INT_MASK: next_rdata[1:0] = int_mask;
            default: next_rresp = `E1C_RESP_DECERR;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= `E1C_RESP_OKAY;
        end else if (rd_go) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= next_rdata;
            S_AXI_RRESP <= next_rresp;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // ==========================================================
    // Interrupt status: cleared by its read, a new event wins
    assign int_event[`E1C_INT_CAS] = cas_change;
    assign int_event[`E1C_INT_NAT] = nat_updated;
    assign int_clr = rd_go && S_AXI_ARADDR == `E1C_OFS_INT_STAT;

    always_ff @(posedge CLK) begin
        if (RST) begin
            int_stat <= '0;
        end else if (int_clr) begin
            int_stat <= int_event;
        end else begin
            int_stat <= int_stat | int_event;
        end
    end

    assign IRQ = |(int_stat & int_mask);

endmodule // e1c_top

// file: verif/e1c_line_model.sv
// Far-end line model: framed CAS nibbles and timeslot 0 octets
`timescale 1ns/10ps
module e1c_line_model (
    input wire logic clk,
    output e1c_pkg::e1c_sig_s sig,
    output e1c_pkg::e1c_ts0_s ts0
);
    import e1c_pkg::*;
    initial begin
        sig = '0;
        ts0 = '0;
    end
    // Entered just after a rising edge; idle payload is inverted so a
    // stale nibble or octet can never pass for a fresh one
    task automatic send_sig(input logic [4:0] t, input logic [3:0] v);
        sig <= '{1'b1, t, v};
        @(posedge clk);
        sig <= '{1'b0, ~t, ~v};
        @(posedge clk);
    endtask
    task automatic send_ts0(input logic f, input logic [7:0] o);
        ts0 <= '{1'b1, f, o};
        @(posedge clk);
        ts0 <= '{1'b0, ~f, ~o};
        @(posedge clk);
    endtask
endmodule // e1c_line_model

// file: verif/e1c_monitor.sv
// Assertion checker for the E1 receive CAS and spare bit block
`timescale 1ns/10ps
`include "e1c_reg_map.svh"
module e1c_monitor #(
    parameter int AW = 16
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [AW-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic [AW-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0] S_AXI_RRESP,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire e1c_pkg::e1c_ts0_s RX_TS0
);
    import e1c_pkg::*;
    logic [AW-1:0] ra;
    logic [2:0] sel;
    e1c_byte_t nat;
    logic seen_a, seen_b, cas_on, ra_cas, ra_ok;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // ==========================================================
    // Shadow state
    assign cas_on = sel == `E1C_SEL_CAS_A || sel == `E1C_SEL_CAS_B;
    assign ra_cas = ra inside {`E1C_OFS_CAS0, `E1C_OFS_CAS1,
        `E1C_OFS_CAS2, `E1C_OFS_CAS3};
    assign ra_ok = ra_cas || ra inside {`E1C_OFS_CTRL, `E1C_OFS_NAT,
        `E1C_OFS_INT_STAT, `E1C_OFS_INT_MASK};
    always_ff @(posedge CLK) begin
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            ra <= S_AXI_ARADDR;
        end
    end
    always_ff @(posedge CLK) begin
        if (RST) begin
            sel <= `E1C_SEL_RESET;
        end else if (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID &&
            S_AXI_WREADY && S_AXI_AWADDR == `E1C_OFS_CTRL) begin
            sel <= S_AXI_WDATA[2:0];
        end
    end
    // The spare register is not reset, so compare only once both kinds seen
    always_ff @(posedge CLK) begin
        if (RST) begin
            seen_a <= 1'b0;
            seen_b <= 1'b0;
        end else if (RX_TS0.valid && RX_TS0.fas) begin
            nat[7] <= RX_TS0.octet[7];
            seen_a <= 1'b1;
        end else if (RX_TS0.valid) begin
            nat[6:0] <= {RX_TS0.octet[7], RX_TS0.octet[5], RX_TS0.octet[4:0]};
            seen_b <= 1'b1;
        end
    end
    // ==========================================================
    // Properties
    sequence s_ar_take;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    sequence s_wr_take;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    a_read_answer: assert property (s_ar_take |=> S_AXI_RVALID)
        else $error("read not answered in one cycle");
    a_write_answer: assert property (s_wr_take |-> ##2 S_AXI_BVALID)
        else $error("write not answered in two cycles");
    a_rdata_held: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
    a_ar_refused: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("address taken while read pending");
    a_ts0_quiet: assert property (
        S_AXI_RVALID && ra == `E1C_OFS_CAS0 |-> !S_AXI_RDATA[7])
        else $error("timeslot 0 flag set");
    a_cas_off_quiet: assert property (
        S_AXI_RVALID && ra_cas && !cas_on |-> S_AXI_RDATA == 32'h0)
        else $error("change flag with signaling off");
    a_spare_match: assert property (
        S_AXI_RVALID && ra == `E1C_OFS_NAT && seen_a && seen_b |->
        S_AXI_RDATA == {24'h0, nat}) else $error("spare bits differ");
    a_unmapped_err: assert property (S_AXI_RVALID && !ra_ok |->
        S_AXI_RRESP == `E1C_RESP_DECERR && S_AXI_RDATA == 32'h0)
        else $error("unmapped read not refused");
endmodule // e1c_monitor
bind e1c_top e1c_monitor #(.AW(AW)) u_mon (.CLK(CLK), .RST(RST),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
    .RX_TS0(RX_TS0));

// file: verif/tb_top.sv
// Self-checking testbench for the E1 receive CAS and spare bit block
`timescale 1ns/10ps
`include "e1c_reg_map.svh"
module tb_top;
    import e1c_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] awaddr = 16'h0, araddr = 16'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    e1c_sig_s sig;
    e1c_ts0_s ts0;
    int err_total = 0, checks = 0;
    always #2 clk = ~clk;
    e1c_top uut (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .RX_SIG(sig), .RX_TS0(ts0), .IRQ(irq));
    e1c_line_model line (.clk(clk), .sig(sig), .ts0(ts0));
    // ==========================================================
    // Bus tasks: handshakes are judged at the falling edge, where
    // nothing moves, and acted on at the next rising edge
    task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic wr(logic [15:0] a, logic [31:0] v);
        bit ha, hw, ok;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!ok) begin
            @(negedge clk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            ok = bvalid === 1'b1;
            r = bresp;
            @(posedge clk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        @(posedge clk);
    endtask
    // A slow read raises ready only once valid is up, so the slave
    // must hold its answer for a cycle
    task automatic rd(logic [15:0] a, bit slow = 1'b0);
        bit ha, rv, ok;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= !slow;
        while (!ok) begin
            @(negedge clk);
            ha = arvalid && arready;
            rv = rvalid === 1'b1;
            ok = rv && rready === 1'b1;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ha) arvalid <= 1'b0;
            if (rv && !ok) rready <= 1'b1;
        end
        rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdx(logic [15:0] a, logic [31:0] exp, bit slow = 1'b0);
        rd(a, slow);
        chk("register", d, exp);
    endtask
    task automatic irq_is(logic v);
        @(negedge clk);
        chk("irq", {31'h0, irq}, {31'h0, v});
        @(posedge clk);
    endtask
    task automatic conclude();
        if (err_total == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    logic [15:0] zr [7] = '{`E1C_OFS_CAS0, `E1C_OFS_CAS1, `E1C_OFS_CAS2,
        `E1C_OFS_CAS3, `E1C_OFS_CTRL, `E1C_OFS_INT_STAT, `E1C_OFS_INT_MASK};
    logic [4:0] hit [8] = '{0, 1, 8, 15, 16, 23, 24, 31};
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (zr[i]) rdx(zr[i], 32'h0);
        for (int t = 0; t < 32; t++) line.send_sig(t[4:0], 4'h5);
        line.send_sig(5'd9, 4'hA);
        rdx(`E1C_OFS_CAS1, 32'h0);
        wr(`E1C_OFS_INT_MASK, 32'h1);
        wr(`E1C_OFS_CTRL, 32'h1);
        foreach (hit[i]) line.send_sig(hit[i], 4'h6);
        irq_is(1'b1);
        rdx(`E1C_OFS_CAS0, 32'h40);
        rdx(`E1C_OFS_CAS1, 32'h81);
        rdx(`E1C_OFS_CAS2, 32'h81, 1'b1);
        rdx(`E1C_OFS_CAS3, 32'h81);
        rdx(`E1C_OFS_CAS0, 32'h0);
        rdx(`E1C_OFS_INT_STAT, 32'h1);
        irq_is(1'b0);
        line.send_sig(5'd1, 4'h6);
        rdx(`E1C_OFS_CAS0, 32'h0);
        for (int c = 0; c < 8; c++) begin
            wr(`E1C_OFS_CTRL, c);
            line.send_sig(5'd2, {1'b1, c[2:0]});
            rdx(`E1C_OFS_CAS0, (c == 1 || c == 3) ? 32'h20 : 32'h0);
        end
        wr(`E1C_OFS_CTRL, 32'h3);
        rdx(`E1C_OFS_INT_STAT, 32'h1);
        // The change and the read clear meet at the same edge
        fork
            line.send_sig(5'd17, 4'h9);
            rd(`E1C_OFS_CAS2);
        join
        chk("register", d, 32'h0);
        rdx(`E1C_OFS_CAS2, 32'h40);
        rd(`E1C_OFS_INT_STAT);
        wr(`E1C_OFS_INT_MASK, 32'h0);
        line.send_ts0(1'b1, 8'h80);
        line.send_ts0(1'b0, 8'h3A);
        rdx(`E1C_OFS_NAT, 32'hBA);
        line.send_ts0(1'b1, 8'h7F);
        rdx(`E1C_OFS_NAT, 32'h3A);
        line.send_ts0(1'b0, 8'hC5);
        rdx(`E1C_OFS_NAT, 32'h45);
        irq_is(1'b0);
        wr(`E1C_OFS_INT_MASK, 32'h2);
        irq_is(1'b1);
        rdx(`E1C_OFS_INT_STAT, 32'h2);
        irq_is(1'b0);
        wr(`E1C_OFS_NAT, 32'hFF);
        chk("bresp", r, `E1C_RESP_OKAY);
        rdx(`E1C_OFS_NAT, 32'h45);
        rdx(16'h0120, 32'h0);
        chk("rresp", r, `E1C_RESP_DECERR);
        wr(16'h0124, 32'h1);
        chk("bresp", r, `E1C_RESP_DECERR);
        conclude();
    end
    initial begin
        #40000;
        err_total++;
        conclude();
    end
endmodule // tb_top
